// file: rtl/skd_dma_defines.vh
// Offsets, descriptor field positions and reset values of the descriptor DMA engine
`ifndef SKD_DMA_DEFINES_VH
`define SKD_DMA_DEFINES_VH

// ----------------------------------------
// Register byte offsets, and address[7:5] selectors of the per-channel head and done arrays
// ----------------------------------------
`define SKD_REG_CTRL      8'h00
`define SKD_REG_RX_SKIP   8'h04
`define SKD_REG_TEARDOWN  8'h08
`define SKD_REG_STATUS    8'h0c
`define SKD_REG_RX_HEAD   8'h10
`define SKD_REG_TX_HEAD   3'h2
`define SKD_REG_TX_DONE   3'h3

// ----------------------------------------
// Descriptor word 3 fields
// ----------------------------------------
`define SKD_W3_FIRST      31
`define SKD_W3_LAST       30
`define SKD_W3_OWN        29
`define SKD_W3_DRAINED    28
`define SKD_W3_SHUTDOWN   27
`define SKD_W3_FCS        26
`define SKD_W3_DIR_EN     20
`define SKD_W3_DIR_LSB    16
`define SKD_W3_RANOUT     20
`define SKD_W3_TAG        16
`define SKD_TX_W3_MASK    32'hfc13_07ff
`define SKD_LEN_MSB       10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SKD_RST_CTRL      4'h0
`define SKD_RST_SKIP      11'h000

`endif

// file: rtl/skd_dma.v
// Descriptor walker for an eight-channel transmit and one receive packet DMA queue
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "skd_dma_defines.vh"

module skd_dma (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // Avalon-MM register slave
  input  wire [7:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  // Descriptor memory master
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [31:0] mem_addr_out,
  output reg  [31:0] mem_wdata_out,
  input  wire        mem_ack_in,
  input  wire [31:0] mem_rdata_in,
  // Transmit buffer requests
  output reg         tx_valid_out,
  output reg  [31:0] tx_addr_out,
  output reg  [10:0] tx_len_out,
  output reg         tx_first_out,
  output reg         tx_last_out,
  output reg         tx_host_fcs_out,
  output reg         tx_directed_out,
  output reg  [1:0]  tx_port_out,
  input  wire        tx_ready_in,
  // Receive packet status from the MAC
  input  wire        rx_pkt_valid_in,
  input  wire [10:0] rx_pkt_len_in,
  input  wire [7:0]  rx_pkt_err_in,
  input  wire        rx_pkt_fcs_kept_in,
  output reg         rx_pkt_ready_out,
  // Receive buffer placement
  output reg         rx_buf_valid_out,
  output reg  [31:0] rx_buf_addr_out,
  output reg  [10:0] rx_buf_len_out
);

  localparam [6:0] ST_IDLE  = 7'b0000001;
  localparam [6:0] ST_FETCH = 7'b0000010;
  localparam [6:0] ST_EVAL  = 7'b0000100;
  localparam [6:0] ST_TXFER = 7'b0001000;
  localparam [6:0] ST_WR    = 7'b0010000;
  localparam [6:0] ST_DONE  = 7'b0100000;
  localparam [6:0] ST_ERR   = 7'b1000000;

  reg [6:0]  st_q;
  reg [6:0]  ret_q;
  reg [31:0] head_q [0:7];
  reg [31:0] done_q [0:7];
  reg [31:0] dw_q [0:3];
  reg [31:0] wa_q [0:2];
  reg [31:0] wd_q [0:2];
  reg [1:0]  wn_q;
  reg [1:0]  wi_q;
  reg [1:0]  widx_q;
  reg [31:0] rx_head_q;
  reg [3:0]  ctrl_q;
  reg [10:0] rx_skip_q;
  reg [7:0]  td_pend_q;
  reg        hosterr_q;
  reg        ack_q;
  reg        rx_mode_q;
  reg        td_mode_q;
  reg        in_pkt_q;
  reg [2:0]  ch_q;
  reg [31:0] cur_q;
  reg [31:0] sop_q;
  reg [31:0] sopw3_q;
  reg [10:0] remain_q;
  reg [10:0] total_q;
  reg [7:0]  rxerr_q;
  reg        rxfcs_q;

  wire       keep_err   = ctrl_q[0];
  wire       keep_short = ctrl_q[1];
  wire       keep_ctrl  = ctrl_q[2];
  wire       tag_set    = ctrl_q[3];
  wire [2:0] reg_idx    = avs_address_in[4:2];
  wire       bus_wr     = avs_write_in & ack_q;

  // ----------------------------------------
  // Channel choice and descriptor decode
  // ----------------------------------------
  reg        tx_any;
  reg [2:0]  tx_ch;
  reg        td_any;
  reg [2:0]  td_ch;
  integer    i;
  integer    j;
  always @* begin
    tx_any = 1'b0;
    tx_ch  = 3'h0;
    td_any = 1'b0;
    td_ch  = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (head_q[i] != 32'h0000_0000) begin
        tx_any = 1'b1;
        tx_ch  = i[2:0];
      end
      if (td_pend_q[i]) begin
        td_any = 1'b1;
        td_ch  = i[2:0];
      end
    end
  end

  wire [31:0] nxt    = dw_q[0];
  wire [31:0] w3     = dw_q[3];
  wire        first  = ~in_pkt_q;
  wire        eop    = w3[`SKD_W3_LAST];
  wire        q_end  = (nxt == 32'h0000_0000);
  // Transmit fragment length: the first fragment loads the frame total
  wire [10:0] tx_rem = first ? w3[`SKD_LEN_MSB:0] : remain_q;
  wire [15:0] tx_bl  = dw_q[2][15:0];
  wire [10:0] tx_n   = ({5'h00, tx_rem} < tx_bl) ? tx_rem : tx_bl[10:0];
  wire        tx_bad = (first & (~w3[`SKD_W3_FIRST] | ~w3[`SKD_W3_OWN] | (w3[`SKD_LEN_MSB:0] == 11'h000)))
                     | (dw_q[1] == 32'h0000_0000) | (tx_bl == 16'h0000)
                     | (~eop & q_end) | (eop & ({5'h00, tx_rem} > tx_bl));
  // Receive fragment length: usable room of the first buffer is the count less the skip
  wire [10:0] rx_bl  = dw_q[2][10:0];
  wire [10:0] rx_av  = first ? rx_bl - rx_skip_q : rx_bl;
  wire [10:0] rx_n   = (remain_q < rx_av) ? remain_q : rx_av;
  wire        rx_bad = (first & (~w3[`SKD_W3_OWN] | (rx_bl <= rx_skip_q)))
                     | (dw_q[1] == 32'h0000_0000) | (rx_bl == 11'h000);
  wire        rx_fin = (remain_q == rx_n);
  wire        rx_out = ~rx_fin & q_end;
  wire        rx_lst = rx_fin | rx_out;
  wire [31:0] rx_w2  = {5'h00, first ? rx_skip_q : 11'h000, 5'h00, rx_n};
  wire        rx_drn = rx_lst & q_end;
  wire [31:0] rx_sw3 = {1'b1, (cur_q == sop_q) | first ? rx_lst : 1'b0, 1'b0,
                        (first & rx_drn), 1'b0, rxfcs_q, rxerr_q[7:3], rx_out,
                        rxerr_q[2:0], tag_set, 5'h00, total_q};
  // Error classes that the MAC settings allow through
  wire        rx_keep = (keep_err | ~|{rx_pkt_err_in[7:5], rx_pkt_err_in[2:0]})
                      & (keep_short | ~rx_pkt_err_in[4]) & (keep_ctrl | ~rx_pkt_err_in[3]);

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      ack_q               <= (avs_read_in | avs_write_in) & ~ack_q;
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_q);
      if (avs_read_in & ~ack_q) begin
        case (avs_address_in[7:5])
          `SKD_REG_TX_HEAD: avs_readdata_out <= head_q[reg_idx];
          `SKD_REG_TX_DONE: avs_readdata_out <= done_q[reg_idx];
          3'h0: begin
            case ({avs_address_in[4:2], 2'b00})
              `SKD_REG_CTRL:     avs_readdata_out <= {28'h000_0000, ctrl_q};
              `SKD_REG_RX_SKIP:  avs_readdata_out <= {21'h00_0000, rx_skip_q};
              `SKD_REG_TEARDOWN: avs_readdata_out <= {24'h00_0000, td_pend_q};
              `SKD_REG_STATUS:   avs_readdata_out <= {24'h00_0000, rx_mode_q, ch_q, ~st_q[0], 2'b00, hosterr_q};
              `SKD_REG_RX_HEAD:  avs_readdata_out <= rx_head_q;
              default:           avs_readdata_out <= 32'h0000_0000;
            endcase
          end
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Descriptor engine
  // ----------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      for (j = 0; j < 8; j = j + 1) begin
        head_q[j] <= 32'h0000_0000;
        done_q[j] <= 32'h0000_0000;
      end
      for (j = 0; j < 4; j = j + 1) begin
        dw_q[j] <= 32'h0000_0000;
      end
      for (j = 0; j < 3; j = j + 1) begin
        wa_q[j] <= 32'h0000_0000;
        wd_q[j] <= 32'h0000_0000;
      end
      wn_q <= 2'h0;
      wi_q <= 2'h0;
      widx_q <= 2'h0;
      rx_head_q <= 32'h0000_0000;
      ctrl_q <= `SKD_RST_CTRL;
      rx_skip_q <= `SKD_RST_SKIP;
      td_pend_q <= 8'h00;
      hosterr_q <= 1'b0;
      rx_mode_q <= 1'b0;
      td_mode_q <= 1'b0;
      in_pkt_q <= 1'b0;
      ch_q <= 3'h0;
      cur_q <= 32'h0000_0000;
      sop_q <= 32'h0000_0000;
      sopw3_q <= 32'h0000_0000;
      remain_q <= 11'h000;
      total_q <= 11'h000;
      rxerr_q <= 8'h00;
      rxfcs_q <= 1'b0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
      mem_wdata_out <= 32'h0000_0000;
      tx_valid_out <= 1'b0;
      tx_addr_out <= 32'h0000_0000;
      tx_len_out <= 11'h000;
      tx_first_out <= 1'b0;
      tx_last_out <= 1'b0;
      tx_host_fcs_out <= 1'b0;
      tx_directed_out <= 1'b0;
      tx_port_out <= 2'h0;
      rx_pkt_ready_out <= 1'b0;
      rx_buf_valid_out <= 1'b0;
      rx_buf_addr_out <= 32'h0000_0000;
      rx_buf_len_out <= 11'h000;
    end else begin
      rx_pkt_ready_out <= 1'b0;
      rx_buf_valid_out <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          in_pkt_q <= 1'b0;
          widx_q <= 2'h0;
          if (td_any) begin
            // Teardown: release the head descriptor and flag it
            td_pend_q[td_ch] <= 1'b0;
            ch_q <= td_ch;
            rx_mode_q <= 1'b0;
            td_mode_q <= 1'b1;
            cur_q <= head_q[td_ch];
            dw_q[0] <= 32'h0000_0000;
            wa_q[0] <= head_q[td_ch] + 32'h0000_000c;
            wd_q[0] <= 32'h8800_0000;
            wn_q <= 2'h1;
            wi_q <= 2'h0;
            ret_q <= ST_DONE;
            st_q <= (head_q[td_ch] != 32'h0000_0000) ? ST_WR : ST_IDLE;
          end else if (rx_pkt_valid_in && !rx_pkt_ready_out) begin
            rx_pkt_ready_out <= 1'b1;
            remain_q <= rx_pkt_len_in;
            total_q <= rx_pkt_len_in;
            rxerr_q <= rx_pkt_err_in;
            rxfcs_q <= rx_pkt_fcs_kept_in;
            cur_q <= rx_head_q;
            rx_mode_q <= 1'b1;
            td_mode_q <= 1'b0;
            if (rx_keep && rx_head_q != 32'h0000_0000) begin
              st_q <= ST_FETCH;
            end
          end else if (tx_any) begin
            ch_q <= tx_ch;
            cur_q <= head_q[tx_ch];
            rx_mode_q <= 1'b0;
            td_mode_q <= 1'b0;
            st_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_req_out & mem_ack_in) begin
            mem_req_out <= 1'b0;
            dw_q[widx_q] <= mem_rdata_in;
            widx_q <= widx_q + 2'h1;
            if (widx_q == 2'h3) begin
              st_q <= ST_EVAL;
            end
          end else if (~mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b0;
            mem_addr_out <= {cur_q[31:2], 2'b00} + {28'h000_0000, widx_q, 2'b00};
          end
        end
        ST_EVAL: begin
          widx_q <= 2'h0;
          if (rx_mode_q) begin
            if (rx_bad) begin
              st_q <= ST_ERR;
            end else begin
              rx_buf_valid_out <= 1'b1;
              rx_buf_addr_out <= dw_q[1] + (first ? {21'h00_0000, rx_skip_q} : 32'h0000_0000);
              rx_buf_len_out <= rx_n;
              remain_q <= remain_q - rx_n;
              in_pkt_q <= 1'b1;
              if (first) begin
                sop_q <= cur_q;
              end
              wa_q[0] <= cur_q + 32'h0000_0008;
              wd_q[0] <= rx_w2;
              wa_q[1] <= cur_q + 32'h0000_000c;
              wa_q[2] <= first ? cur_q + 32'h0000_000c : sop_q + 32'h0000_000c;
              wd_q[1] <= {2'b01, 1'b0, rx_drn, 28'h000_0000};
              wd_q[2] <= rx_sw3;
              wi_q <= 2'h0;
              if (!rx_lst) begin
                wn_q <= 2'h1;
                ret_q <= ST_FETCH;
                cur_q <= nxt;
              end else begin
                wn_q <= 2'h3;
                wd_q[1] <= rx_sw3;
                if (!first) begin
                  wd_q[1] <= {2'b01, 1'b0, rx_drn, 28'h000_0000};
                end
                ret_q <= ST_DONE;
              end
              st_q <= ST_WR;
            end
          end else if (tx_bad) begin
            st_q <= ST_ERR;
          end else begin
            if (first) begin
              sop_q <= cur_q;
              sopw3_q <= w3 & `SKD_TX_W3_MASK & ~(32'h1 << `SKD_W3_OWN);
              tx_host_fcs_out <= w3[`SKD_W3_FCS];
              tx_directed_out <= w3[`SKD_W3_DIR_EN];
              tx_port_out <= w3[`SKD_W3_DIR_LSB+1:`SKD_W3_DIR_LSB];
            end
            tx_valid_out <= 1'b1;
            tx_addr_out <= dw_q[1] + (first ? {16'h0000, dw_q[2][31:16]} : 32'h0000_0000);
            tx_len_out <= tx_n;
            tx_first_out <= first;
            tx_last_out <= eop;
            remain_q <= tx_rem;
            st_q <= ST_TXFER;
          end
        end
        ST_TXFER: begin
          if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
            remain_q <= remain_q - tx_len_out;
            in_pkt_q <= 1'b1;
            if (eop) begin
              // Last fragment first, then release of the first one
              wa_q[0] <= cur_q + 32'h0000_000c;
              wd_q[0] <= (w3 & `SKD_TX_W3_MASK) | ({31'h0000_0000, q_end} << `SKD_W3_DRAINED);
              wa_q[1] <= sop_q + 32'h0000_000c;
              wd_q[1] <= (cur_q == sop_q) ? (sopw3_q | ({31'h0000_0000, q_end} << `SKD_W3_DRAINED))
                                          : sopw3_q;
              wn_q <= 2'h2;
              wi_q <= (cur_q == sop_q) ? 2'h1 : 2'h0;
              ret_q <= ST_DONE;
              st_q <= ST_WR;
            end else begin
              cur_q <= nxt;
              st_q <= ST_FETCH;
            end
          end
        end
        ST_WR: begin
          if (mem_req_out & mem_ack_in) begin
            mem_req_out <= 1'b0;
            wi_q <= wi_q + 2'h1;
            if (wi_q + 2'h1 == wn_q) begin
              st_q <= ret_q;
            end
          end else if (~mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b1;
            mem_addr_out <= wa_q[wi_q];
            mem_wdata_out <= wd_q[wi_q];
          end
        end
        ST_DONE: begin
          in_pkt_q <= 1'b0;
          if (rx_mode_q) begin
            rx_head_q <= nxt;
          end else begin
            head_q[ch_q] <= nxt;
            if (q_end) begin
              done_q[ch_q] <= cur_q;
            end
          end
          st_q <= ST_IDLE;
        end
        ST_ERR: begin
          hosterr_q <= 1'b1;
          if (rx_mode_q) begin
            rx_head_q <= 32'h0000_0000;
          end else begin
            head_q[ch_q] <= 32'h0000_0000;
          end
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      // Bus writes; a host error raised in this cycle wins over its clear
      if (bus_wr) begin
        case (avs_address_in[7:5])
          `SKD_REG_TX_HEAD: head_q[reg_idx] <= avs_writedata_in;
          3'h0: begin
            case ({avs_address_in[4:2], 2'b00})
              `SKD_REG_CTRL:     ctrl_q <= avs_writedata_in[3:0];
              `SKD_REG_RX_SKIP:  rx_skip_q <= avs_writedata_in[10:0];
              `SKD_REG_TEARDOWN: td_pend_q[avs_writedata_in[2:0]] <= 1'b1;
              `SKD_REG_STATUS:   hosterr_q <= hosterr_q & ~avs_writedata_in[0] | st_q[6];
              `SKD_REG_RX_HEAD:  rx_head_q <= avs_writedata_in;
              default: begin
              end
            endcase
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule // skd_dma

// file: rtl/skd_dma_unused_placeholder_removed.v
`timescale 1ns/100ps

// file: test/skd_dma_properties.sv
// Concurrent checks on the descriptor DMA engine ports
`timescale 1ns/100ps
module skd_dma_properties (
  // Clock and reset
  input wire        clk_in,
  input wire        rst_in,
  // Register bus
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire        avs_waitrequest_out,
  // Memory master
  input wire        mem_req_out,
  input wire        mem_we_out,
  input wire [31:0] mem_addr_out,
  input wire [31:0] mem_wdata_out,
  input wire        mem_ack_in,
  // Transmit and receive
  input wire        tx_valid_out,
  input wire [31:0] tx_addr_out,
  input wire [10:0] tx_len_out,
  input wire        tx_ready_in,
  input wire        rx_pkt_valid_in,
  input wire        rx_pkt_ready_out,
  input wire        rx_buf_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("register access not answered in the next cycle");
  bus_single_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  bus_idle_a: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("waitrequest low without a request");
  mem_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
    && $stable(mem_we_out) && $stable(mem_wdata_out))
    else $error("memory request changed before acknowledge");
  mem_gap_a: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
    else $error("memory request not dropped after acknowledge");
  word_align_a: assert property (mem_req_out |-> mem_addr_out[1:0] == 2'b00)
    else $error("descriptor access not word aligned");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_addr_out)
    && $stable(tx_len_out))
    else $error("transmit fragment changed before ready");
  rx_pulse_a: assert property (rx_pkt_ready_out |=> !rx_pkt_ready_out)
    else $error("receive ready longer than one cycle");
  rx_cause_a: assert property (rx_pkt_ready_out |-> $past(rx_pkt_valid_in))
    else $error("receive ready without a packet");
  rx_buf_pulse_a: assert property (rx_buf_valid_out |=> !rx_buf_valid_out)
    else $error("receive buffer strobe longer than one cycle");
endmodule // skd_dma_properties

bind skd_dma skd_dma_properties u_props (.clk_in(clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .mem_req_out(mem_req_out),
  .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
  .mem_ack_in(mem_ack_in), .tx_valid_out(tx_valid_out), .tx_addr_out(tx_addr_out), .tx_len_out(tx_len_out),
  .tx_ready_in(tx_ready_in), .rx_pkt_valid_in(rx_pkt_valid_in), .rx_pkt_ready_out(rx_pkt_ready_out),
  .rx_buf_valid_out(rx_buf_valid_out));

// file: test/skd_host_mem.sv
// Host descriptor memory answering the engine's memory master
`timescale 1ns/100ps
module skd_host_mem (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // Stall length in cycles
  input  wire [3:0]  slow_in,
  // Memory slave
  input  wire        mem_req_in,
  input  wire        mem_we_in,
  input  wire [31:0] mem_addr_in,
  input  wire [31:0] mem_wdata_in,
  output reg         mem_ack_out,
  output reg  [31:0] mem_rdata_out
);
  reg [31:0] mem_q [0:255];
  reg [3:0]  wait_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= 32'h5a5a_a5a5;
      wait_q        <= 4'h0;
    end else begin
      mem_ack_out   <= 1'b0;
      // Stale read data toggles so it never looks valid
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in && !mem_ack_out) begin
        if (wait_q >= slow_in) begin
          wait_q      <= 4'h0;
          mem_ack_out <= 1'b1;
          if (mem_we_in)
            mem_q[mem_addr_in[9:2]] <= mem_wdata_in;
          else
            mem_rdata_out <= mem_q[mem_addr_in[9:2]];
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule // skd_host_mem

// file: test/tb.sv
// Self-checking bench for the descriptor DMA engine
`timescale 1ns/100ps
`include "skd_dma_defines.vh"
module tb;
  reg         clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg  [7:0]  avs_address_in = 8'h00;
  reg         avs_read_in = 1'b0;
  reg         avs_write_in = 1'b0;
  reg  [31:0] avs_writedata_in = 32'h0;
  wire [31:0] avs_readdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in, tx_addr_out, rx_buf_addr_out;
  wire        avs_waitrequest_out, mem_req_out, mem_we_out, mem_ack_in, tx_valid_out, tx_first_out;
  wire        tx_last_out, tx_host_fcs_out, tx_directed_out, rx_pkt_ready_out, rx_buf_valid_out;
  wire [10:0] tx_len_out, rx_buf_len_out;
  wire [1:0]  tx_port_out;
  reg         tx_ready_in = 1'b0;
  reg         rx_pkt_valid_in = 1'b0;
  reg  [10:0] rx_pkt_len_in = 11'h0;
  reg  [7:0]  rx_pkt_err_in = 8'h0;
  reg         rx_pkt_fcs_kept_in = 1'b0;
  reg  [3:0]  slow = 4'h0;
  integer     bad_count = 0;
  integer     checks_done = 0;
  integer     rxb_n = 0;
  reg  [42:0] rxb_last;
  reg  [31:0] rd;
  reg  [31:0] txa_q [$];
  reg  [16:0] txf_q [$];

  skd_dma DUT (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
    .mem_ack_in, .mem_rdata_in, .tx_valid_out, .tx_addr_out, .tx_len_out, .tx_first_out, .tx_last_out,
    .tx_host_fcs_out, .tx_directed_out, .tx_port_out, .tx_ready_in, .rx_pkt_valid_in, .rx_pkt_len_in,
    .rx_pkt_err_in, .rx_pkt_fcs_kept_in, .rx_pkt_ready_out, .rx_buf_valid_out, .rx_buf_addr_out,
    .rx_buf_len_out);
  skd_host_mem host_mem (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .mem_req_in(mem_req_out),
    .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

  always #25 clk_in = ~clk_in;

  // Fragment sink stalls one cycle per fragment and logs what it takes
  always @(posedge clk_in) begin
    tx_ready_in <= tx_valid_out && !tx_ready_in;
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
      txa_q.push_back(tx_addr_out);
      txf_q.push_back({tx_first_out, tx_last_out, tx_host_fcs_out, tx_directed_out, tx_port_out, tx_len_out});
    end
    if (rx_buf_valid_out === 1'b1) begin
      rxb_n = rxb_n + 1;
      rxb_last = {rx_buf_len_out, rx_buf_addr_out};
    end
  end

  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task bus_cycle(input rd_en, input [7:0] a, input [31:0] d);
    integer n;
    begin
      avs_address_in   <= a;
      avs_writedata_in <= d;
      avs_read_in      <= rd_en;
      avs_write_in     <= !rd_en;
      n = 0;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0 && n < 100) begin
        @(posedge clk_in);
        n = n + 1;
      end
      rd = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
      if (n >= 100)
        check(32'h1, 32'h0, "bus answer");
      @(posedge clk_in);
    end
  endtask

  task put_desc(input [31:0] a, input [31:0] w0, input [31:0] w1, input [31:0] w2, input [31:0] w3);
    begin
      host_mem.mem_q[a[9:2]] = w0;
      host_mem.mem_q[a[9:2] + 8'd1] = w1;
      host_mem.mem_q[a[9:2] + 8'd2] = w2;
      host_mem.mem_q[a[9:2] + 8'd3] = w3;
    end
  endtask

  function [31:0] mw(input [31:0] a);
    mw = host_mem.mem_q[a[9:2]];
  endfunction

  task send_pkt(input [10:0] len, input [7:0] err, input kept);
    integer n;
    begin
      rx_pkt_len_in      <= len;
      rx_pkt_err_in      <= err;
      rx_pkt_fcs_kept_in <= kept;
      rx_pkt_valid_in    <= 1'b1;
      n = 0;
      @(posedge clk_in);
      while (rx_pkt_ready_out !== 1'b1 && n < 500) begin
        @(posedge clk_in);
        n = n + 1;
      end
      rx_pkt_valid_in <= 1'b0;
      check(n < 500, 32'h1, "rx taken");
      @(posedge clk_in);
      n = 0;
      rd = 32'h8;
      while (rd[3] !== 1'b0 && n < 200) begin
        bus_cycle(1'b1, `SKD_REG_STATUS, 32'h0);
        n = n + 1;
      end
    end
  endtask

  task test_regs;
    begin
      bus_cycle(1'b1, `SKD_REG_CTRL, 32'h0);
      check(rd, {28'h0, `SKD_RST_CTRL}, "ctrl reset");
      bus_cycle(1'b1, `SKD_REG_RX_SKIP, 32'h0);
      check(rd, {21'h0, `SKD_RST_SKIP}, "skip reset");
      bus_cycle(1'b0, 8'h24, 32'hffff_ffff);
      bus_cycle(1'b1, 8'h24, 32'h0);
      check(rd, 32'h0, "unmapped read");
      bus_cycle(1'b0, `SKD_REG_RX_SKIP, 32'h4);
      bus_cycle(1'b1, `SKD_REG_RX_SKIP, 32'h0);
      check(rd, 32'h4, "rx skip setting");
    end
  endtask

  task test_tx;
    integer n;
    begin
      // Two fragments, total shorter than the buffers, reserved bit 12 set
      put_desc(32'h100, 32'h110, 32'h1000, 32'h0002_000a, 32'ha411_100e);
      put_desc(32'h110, 32'h0, 32'h2000, 32'h0000_0008, 32'h4000_0000);
      bus_cycle(1'b0, 8'h40, 32'h100);
      n = 0;
      rd = 32'h0;
      while (rd !== 32'h110 && n < 200) begin
        bus_cycle(1'b1, 8'h60, 32'h0);
        n = n + 1;
      end
      check(rd, 32'h110, "tx done ptr");
      bus_cycle(1'b1, 8'h40, 32'h0);
      check(rd, 32'h0, "tx head");
      check(mw(32'h10c), 32'h8411_000e, "tx first word3");
      check(mw(32'h11c), 32'h5000_0000, "tx last word3");
      check(txa_q.size(), 32'h2, "fragment count");
      check(txa_q[0], 32'h1002, "first addr");
      check(txf_q[0], {1'b1, 1'b0, 1'b1, 1'b1, 2'd1, 11'd10}, "first fragment");
      check(txa_q[1], 32'h2000, "last addr");
      check({txf_q[1][16:15], txf_q[1][10:0]}, {2'b01, 11'd4}, "last fragment");
    end
  endtask

  task test_rx;
    integer n0;
    begin
      slow <= 4'h3;
      bus_cycle(1'b0, `SKD_REG_CTRL, 32'h9);
      put_desc(32'h140, 32'h150, 32'h3000, 32'h0000_0014, 32'h2000_0000);
      put_desc(32'h150, 32'h0, 32'h4000, 32'h0000_0014, 32'h0);
      bus_cycle(1'b0, `SKD_REG_RX_HEAD, 32'h140);
      n0 = rxb_n;
      send_pkt(11'd30, 8'h01, 1'b1);
      check(rxb_n - n0, 32'h2, "rx buffers");
      check(mw(32'h14c), 32'h8403_001e, "rx first word3");
      check(mw(32'h15c), 32'h5000_0000, "rx last word3");
      check(mw(32'h148) & 32'hffff_f800, 32'h0004_0000, "rx skip field");
    end
  endtask

  task test_drop;
    integer n0;
    begin
      bus_cycle(1'b0, `SKD_REG_CTRL, 32'h0);
      put_desc(32'h180, 32'h0, 32'h5000, 32'h0000_0080, 32'h2000_0000);
      bus_cycle(1'b0, `SKD_REG_RX_HEAD, 32'h180);
      n0 = rxb_n;
      send_pkt(11'd64, 8'h08, 1'b0);
      check(rxb_n - n0, 32'h0, "dropped buffers");
      check(mw(32'h18c), 32'h2000_0000, "dropped word3");
      bus_cycle(1'b0, `SKD_REG_CTRL, 32'h4);
      send_pkt(11'd64, 8'h08, 1'b0);
      check(rxb_n - n0, 32'h1, "kept buffers");
      check(rxb_last[31:0], 32'h5004, "rx buffer addr");
      check(rxb_last[42:32], 32'd64, "rx buffer len");
      check(mw(32'h18c), 32'hd020_0040, "control word3");
      check(mw(32'h188), 32'h0004_0040, "control word2");
    end
  endtask

  task test_td;
    integer n;
    begin
      put_desc(32'h1c0, 32'h1d0, 32'h6000, 32'h10, 32'he000_0010);
      put_desc(32'h1d0, 32'h0, 32'h7000, 32'h10, 32'he000_0010);
      bus_cycle(1'b0, 8'h48, 32'h1c0);
      bus_cycle(1'b0, `SKD_REG_TEARDOWN, 32'h2);
      n = 0;
      rd = 32'h0;
      while (rd !== 32'h1d0 && n < 200) begin
        bus_cycle(1'b1, 8'h68, 32'h0);
        n = n + 1;
      end
      check(mw(32'h1dc), 32'h8800_0000, "teardown word3");
      check(mw(32'h1cc), 32'hc000_0010, "released word3");
      check(txf_q[2], 17'h1_8010, "device fcs fragment");
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count = bad_count + 1;
    test_done;
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    test_regs;
    test_tx;
    test_rx;
    test_drop;
    test_td;
    test_done;
  end
endmodule // tb
